/* File: core/aml_cfg.svh */
// Purpose: register offsets, reset values and timing counts of the axis motion limiter
// Assumes: lengths in 0.0001 mm, feeds in 0.0001 mm/min, signed positions
// Notes: Operation list below
// Operation
// - rapid feed capped at rapid_feed_limit
// - approach direction plus or minus
// - stop short by overrun; zero disables
// - approach leg runs at approach_feedrate
// - programmed feed capped at max_programmed_feed
// - jog without feed uses manual_jog_feed
// - probing in jog uses probe_feedrate
// - slave checks coupled following error difference
// - feedforward select steers derivative gain use
// - advanced on analog axis acts as yes
// - after marker, shift home_offset_shift at seek feed
// - contact after standstill for stall window
// - after contact output contact_hold_command
// - round corner uses round_corner_window for position
// - units digit selects marker pulse type
// - tens digit selects normal or smooth stop
// - nonzero marker type reports position minus offset; code also subtracts it when only the tens digit is nonzero
// - short move flag below short_move_threshold
// - after home switch seek marker at seek feed
`ifndef AML_CFG_SVH
`define AML_CFG_SVH
`define AML_NREG         17
`define AML_IDX_RAPID    0
`define AML_IDX_OVERRUN  1
`define AML_IDX_APPFEED  2
`define AML_IDX_MAX_PROGRAMMED_FEED  3
`define AML_IDX_MANUAL_JOG_FEED  4
`define AML_IDX_PROBE_FEEDRATE  5
`define AML_IDX_COUPLE   6
`define AML_IDX_CTRL     7
`define AML_IDX_SHIFT    8
`define AML_IDX_MSEEK    9
`define AML_IDX_STALLT   10
`define AML_IDX_STALLM   11
`define AML_IDX_HOLD     12
`define AML_IDX_RCWIN    13
`define AML_IDX_INPOS    14
`define AML_IDX_ZOFF     15
`define AML_IDX_SHORT_MOVE_THRESHOLD  16
`define AML_ADDR_STATUS  8'h44
`define AML_CTRL_FFSEL   1:0
`define AML_CTRL_DIR     2
`define AML_CTRL_SLAVE   3
`define AML_CTRL_DIGITAL 4
`define AML_CTRL_RC      5
`define AML_CTRL_MUNITS  11:8
`define AML_CTRL_MTENS   15:12
`define AML_RST_RAPID    32'h05f5_e100
`define AML_RST_MAX_PROGRAMMED_FEED  32'h02fa_f080
`define AML_RST_MANUAL_JOG_FEED  32'h0098_9680
`define AML_RST_PROBE_FEEDRATE  32'h000f_4240
`define AML_RST_COUPLE   32'h0000_2710
`define AML_RST_CTRL     32'h0000_0001
`define AML_RST_MSEEK    32'h000f_4240
`define AML_RST_RCWIN    32'h0000_03e8
`define AML_RST_INPOS    32'h0000_0064
`define AML_HOLD_MAX     15'h7fff
`define AML_MS_NS        1000000
`define AML_CLK_NS       40
`define AML_MS_CYC       (`AML_MS_NS / `AML_CLK_NS)
`endif

/* File: core/aml_pkg.sv */
// Purpose: types of the axis motion limiter
// Assumes: nothing beyond the config header
// Notes: state codes are one-hot
package aml_pkg;
	typedef enum logic [7:0] {
		ST_IDLE  = 8'h01,
		ST_MOVE  = 8'h02,
		ST_APPR  = 8'h04,
		ST_SEEK1 = 8'h08,
		ST_SEEK2 = 8'h10,
		ST_SHIFT = 8'h20,
		ST_HSTOP = 8'h40,
		ST_HOLD  = 8'h80
	} aml_state_type;
	typedef enum logic [2:0] {
		K_RAPID = 3'h0,
		K_FEED  = 3'h1,
		K_JOG   = 3'h2,
		K_PROBE = 3'h3,
		K_HOME  = 3'h4,
		K_HSTOP = 3'h5
	} aml_kind_type;
	typedef enum logic [1:0] {
		FF_NO  = 2'h0,
		FF_YES = 2'h1,
		FF_ADV = 2'h2
	} aml_ffsel_type;
endpackage

/* File: core/aml_axis.sv */
// Purpose: per-axis feed limits, approach, homing shift, hardstop and position flags
// Assumes: position and error inputs come from logic on clk; marker and switch are pins
// Notes: outputs feed a downstream interpolator; all lengths in 0.0001 mm
`include "aml_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module aml_axis #(
	parameter int MS_CYC = `AML_MS_CYC
) (
	// clock, reset, enable
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        ce,
	// register port
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [31:0] rdata_q,
	// motion commands
	input  wire logic        cmd_start,
	input  wire logic        cmd_stop,
	input  wire logic [2:0]  cmd_kind,
	input  wire logic [31:0] cmd_target,
	input  wire logic [31:0] cmd_feed,
	// feedback
	input  wire logic [31:0] feedback_pos,
	input  wire logic [31:0] ferr_own,
	input  wire logic [31:0] ferr_master,
	input  wire logic        marker_pin,
	input  wire logic        home_switch_pin,
	// motion outputs
	output logic [31:0] setpoint_q,
	output logic [31:0] feed_q,
	output logic        busy_q,
	output logic        done_q,
	output logic        in_pos_q,
	output logic        short_move_q,
	output logic        coupled_fault_q,
	output logic        contact_q,
	output logic        hold_active_q,
	output logic [14:0] hold_cmd_q,
	// servo mode and reporting
	output logic        dgain_ferr_q,
	output logic        dgain_accel_q,
	output logic [1:0]  marker_kind_q,
	output logic        smooth_stop_q,
	output logic [31:0] pos_report_q
);
	typedef struct packed {
		logic [`AML_NREG-1:0][31:0] cfg;
		logic [1:0]  mk_s;
		logic        mk_prev;
		logic [1:0]  hs_s;
		aml_pkg::aml_state_type st;
		aml_pkg::aml_kind_type kind;
		logic        uni;
		logic [31:0] final_tgt;
		logic [31:0] stall_ref;
		logic [31:0] ms_cnt;
		logic [15:0] win_cnt;
		logic [31:0] setp;
		logic [31:0] feed;
		logic        busy;
		logic        done;
		logic        inpos;
		logic        shortm;
		logic        cfault;
		logic        contact;
		logic        hold_on;
		logic [14:0] hold;
		logic        dgf;
		logic        dga;
		logic [1:0]  mkind;
		logic        smooth;
		logic [31:0] posrep;
		logic [31:0] rdata;
	} aml_regs_type;

	aml_regs_type r_q;
	aml_regs_type r_d;
	logic [1:0]   rst_q;
	logic         rst_n;

	function automatic logic [31:0] adiff(input logic [31:0] a, input logic [31:0] b);
		logic signed [32:0] d;
		d = $signed({a[31], a}) - $signed({b[31], b});
		if (d < 0)
			d = -d;
		return d[32] ? 32'hffff_ffff : d[31:0];
	endfunction

	function automatic logic [31:0] umin(input logic [31:0] a, input logic [31:0] b);
		return (a < b) ? a : b;
	endfunction

	// the release is synchronised so every flop leaves reset on the same edge
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			rst_q <= 2'h0;
		else
			rst_q <= {rst_q[0], 1'b1};
	end
	assign rst_n = rst_q[1];

	logic [31:0] c_rapid, c_ov, c_app, c_max, c_jog, c_prb, c_cpl, c_ctl;
	logic [31:0] c_shift, c_mseek, c_stallm, c_rcwin, c_inpos, c_zoff, c_minmv;
	assign c_rapid  = r_q.cfg[`AML_IDX_RAPID];
	assign c_ov     = r_q.cfg[`AML_IDX_OVERRUN];
	assign c_app    = r_q.cfg[`AML_IDX_APPFEED];
	assign c_max    = r_q.cfg[`AML_IDX_MAX_PROGRAMMED_FEED];
	assign c_jog    = r_q.cfg[`AML_IDX_MANUAL_JOG_FEED];
	assign c_prb    = r_q.cfg[`AML_IDX_PROBE_FEEDRATE];
	assign c_cpl    = r_q.cfg[`AML_IDX_COUPLE];
	assign c_ctl    = r_q.cfg[`AML_IDX_CTRL];
	assign c_shift  = r_q.cfg[`AML_IDX_SHIFT];
	assign c_mseek  = r_q.cfg[`AML_IDX_MSEEK];
	assign c_stallm = r_q.cfg[`AML_IDX_STALLM];
	assign c_rcwin  = r_q.cfg[`AML_IDX_RCWIN];
	assign c_inpos  = r_q.cfg[`AML_IDX_INPOS];
	assign c_zoff   = r_q.cfg[`AML_IDX_ZOFF];
	assign c_minmv  = r_q.cfg[`AML_IDX_SHORT_MOVE_THRESHOLD];

	always_comb begin
		logic [31:0] win;
		logic        arrived;
		logic        mk_rise;
		logic [31:0] app_pt;
		logic [31:0] stall_t;
		logic [1:0]  ffsel;
		logic [4:0]  idx;
		r_d = r_q;
		win = 32'h0;
		arrived = 1'b0;
		mk_rise = 1'b0;
		app_pt = 32'h0;
		stall_t = 32'h0;
		ffsel = 2'h0;
		idx = addr[6:2];
		r_d.done = 1'b0;

		// pins pass two flops; edge detection looks only at the second
		r_d.mk_s = {r_q.mk_s[0], marker_pin};
		r_d.hs_s = {r_q.hs_s[0], home_switch_pin};
		r_d.mk_prev = r_q.mk_s[1];
		mk_rise = r_q.mk_s[1] && !r_q.mk_prev;

		if (wr && addr[1:0] == 2'h0 && addr[7] == 1'b0 && idx < 5'(`AML_NREG))
			r_d.cfg[idx] = wdata;
		r_d.rdata = 32'h0;
		if (rd) begin
			if (addr[1:0] == 2'h0 && addr[7] == 1'b0 && idx < 5'(`AML_NREG))
				r_d.rdata = r_q.cfg[idx];
			else if (addr == `AML_ADDR_STATUS)
				r_d.rdata = {16'h0, r_q.st, 3'h0, r_q.hold_on, r_q.contact,
					r_q.cfault, r_q.inpos, r_q.busy};
		end

		// round corner widens the in-position zone
		win = c_ctl[`AML_CTRL_RC] ? c_rcwin : c_inpos;
		arrived = adiff(r_q.setp, feedback_pos) <= win;
		r_d.inpos = arrived;

		// only the slave axis carries the limit
		r_d.cfault = c_ctl[`AML_CTRL_SLAVE] && (adiff(ferr_own, ferr_master) > c_cpl);

		// advanced only helps a digital drive; analog falls back to yes
		ffsel = c_ctl[`AML_CTRL_FFSEL];
		if (ffsel == aml_pkg::FF_ADV && !c_ctl[`AML_CTRL_DIGITAL])
			ffsel = aml_pkg::FF_YES;
		r_d.dgf = (ffsel == aml_pkg::FF_NO);
		r_d.dga = (ffsel == aml_pkg::FF_YES) || (ffsel == aml_pkg::FF_ADV);

		r_d.mkind = c_ctl[9:8];
		r_d.smooth = (c_ctl[`AML_CTRL_MTENS] == 4'h1);
		if (c_ctl[`AML_CTRL_MUNITS] != 4'h0 || c_ctl[`AML_CTRL_MTENS] != 4'h0)
			r_d.posrep = feedback_pos - c_zoff;
		else
			r_d.posrep = feedback_pos;

		unique case (r_q.st)
			aml_pkg::ST_IDLE: begin
				r_d.busy = 1'b0;
				if (cmd_start) begin
					r_d.busy = 1'b1;
					r_d.contact = 1'b0;
					r_d.hold_on = 1'b0;
					r_d.kind = aml_pkg::aml_kind_type'(cmd_kind);
					r_d.final_tgt = cmd_target;
					r_d.setp = cmd_target;
					r_d.uni = 1'b0;
					r_d.shortm = adiff(cmd_target, feedback_pos) < c_minmv;
					r_d.st = aml_pkg::ST_MOVE;
					case (cmd_kind)
						3'(aml_pkg::K_RAPID): begin
							r_d.feed = c_rapid;
							if (c_ov != 32'h0) begin
								// stop short on the side chosen, then creep in
								app_pt = c_ctl[`AML_CTRL_DIR] ? cmd_target + c_ov
									: cmd_target - c_ov;
								r_d.setp = app_pt;
								r_d.uni = 1'b1;
							end
						end
						3'(aml_pkg::K_JOG): r_d.feed = (cmd_feed == 32'h0) ? c_jog
							: umin(cmd_feed, c_max);
						3'(aml_pkg::K_PROBE): r_d.feed = c_prb;
						3'(aml_pkg::K_HOME): begin
							r_d.feed = cmd_feed;
							r_d.shortm = 1'b0;
							r_d.st = aml_pkg::ST_SEEK1;
						end
						default: r_d.feed = umin(cmd_feed, c_max);
					endcase
				end
			end
			aml_pkg::ST_MOVE: begin
				if (arrived) begin
					if (r_q.uni) begin
						r_d.setp = r_q.final_tgt;
						r_d.feed = c_app;
						r_d.st = aml_pkg::ST_APPR;
					end else if (r_q.kind == aml_pkg::K_HSTOP) begin
						r_d.done = 1'b1;
						r_d.st = aml_pkg::ST_IDLE;
					end else begin
						r_d.done = 1'b1;
						r_d.st = aml_pkg::ST_IDLE;
					end
				end else if (r_q.kind == aml_pkg::K_HSTOP) begin
					r_d.stall_ref = feedback_pos;
					r_d.ms_cnt = 32'h0;
					r_d.win_cnt = 16'h0;
					r_d.st = aml_pkg::ST_HSTOP;
				end
			end
			aml_pkg::ST_APPR: begin
				if (arrived) begin
					r_d.done = 1'b1;
					r_d.st = aml_pkg::ST_IDLE;
				end
			end
			aml_pkg::ST_SEEK1: begin
				if (r_q.hs_s[1]) begin
					r_d.feed = c_mseek;
					r_d.st = aml_pkg::ST_SEEK2;
				end
			end
			aml_pkg::ST_SEEK2: begin
				if (mk_rise) begin
					if (c_shift != 32'h0) begin
						r_d.setp = feedback_pos + c_shift;
						r_d.feed = c_mseek;
						r_d.st = aml_pkg::ST_SHIFT;
					end else begin
						r_d.setp = feedback_pos;
						r_d.done = 1'b1;
						r_d.st = aml_pkg::ST_IDLE;
					end
				end
			end
			aml_pkg::ST_SHIFT: begin
				if (arrived) begin
					r_d.done = 1'b1;
					r_d.st = aml_pkg::ST_IDLE;
				end
			end
			aml_pkg::ST_HSTOP: begin
				stall_t = {16'h0, r_q.cfg[`AML_IDX_STALLT][15:0]};
				if (adiff(feedback_pos, r_q.stall_ref) > c_stallm) begin
					r_d.stall_ref = feedback_pos;
					r_d.ms_cnt = 32'h0;
					r_d.win_cnt = 16'h0;
				end else if ({16'h0, r_q.win_cnt} >= stall_t) begin
					r_d.contact = 1'b1;
					r_d.hold_on = 1'b1;
					r_d.hold = r_q.cfg[`AML_IDX_HOLD][14:0];
					r_d.done = 1'b1;
					r_d.st = aml_pkg::ST_HOLD;
				end else if (r_q.ms_cnt == 32'(MS_CYC - 1)) begin
					r_d.ms_cnt = 32'h0;
					r_d.win_cnt = r_q.win_cnt + 16'h1;
				end else begin
					r_d.ms_cnt = r_q.ms_cnt + 32'h1;
				end
			end
			aml_pkg::ST_HOLD: begin
				// residual push stays until the move is cancelled
				r_d.hold = r_q.cfg[`AML_IDX_HOLD][14:0];
				r_d.busy = 1'b0;
			end
		endcase

		if (cmd_stop) begin
			r_d.st = aml_pkg::ST_IDLE;
			r_d.busy = 1'b0;
			r_d.hold_on = 1'b0;
			r_d.feed = 32'h0;
		end

		// the residual command is zeroed in the register so the pin never glitches through a mux
		if (!r_d.hold_on)
			r_d.hold = 15'h0;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r_q <= '0;
			r_q.st <= aml_pkg::ST_IDLE;
			r_q.kind <= aml_pkg::K_RAPID;
			r_q.cfg[`AML_IDX_RAPID] <= `AML_RST_RAPID;
			r_q.cfg[`AML_IDX_MAX_PROGRAMMED_FEED] <= `AML_RST_MAX_PROGRAMMED_FEED;
			r_q.cfg[`AML_IDX_MANUAL_JOG_FEED] <= `AML_RST_MANUAL_JOG_FEED;
			r_q.cfg[`AML_IDX_PROBE_FEEDRATE] <= `AML_RST_PROBE_FEEDRATE;
			r_q.cfg[`AML_IDX_COUPLE] <= `AML_RST_COUPLE;
			r_q.cfg[`AML_IDX_CTRL] <= `AML_RST_CTRL;
			r_q.cfg[`AML_IDX_MSEEK] <= `AML_RST_MSEEK;
			r_q.cfg[`AML_IDX_RCWIN] <= `AML_RST_RCWIN;
			r_q.cfg[`AML_IDX_INPOS] <= `AML_RST_INPOS;
		end else if (ce) begin
			r_q <= r_d;
		end
	end

	assign rdata_q         = r_q.rdata;
	assign setpoint_q      = r_q.setp;
	assign feed_q          = r_q.feed;
	assign busy_q          = r_q.busy;
	assign done_q          = r_q.done;
	assign in_pos_q        = r_q.inpos;
	assign short_move_q    = r_q.shortm;
	assign coupled_fault_q = r_q.cfault;
	assign contact_q       = r_q.contact;
	assign hold_active_q   = r_q.hold_on;
	assign hold_cmd_q      = r_q.hold;
	assign dgain_ferr_q    = r_q.dgf;
	assign dgain_accel_q   = r_q.dga;
	assign marker_kind_q   = r_q.mkind;
	assign smooth_stop_q   = r_q.smooth;
	assign pos_report_q    = r_q.posrep;

	a_rapid_feed_cap: assert property (@(posedge clk) disable iff (!rst_n)
		(r_q.st == aml_pkg::ST_MOVE && r_q.kind == aml_pkg::K_RAPID) |-> feed_q == c_rapid)
		else $error("rapid feed not at limit");
	a_uni_off_direct: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && !cmd_stop && cmd_start && r_q.st == aml_pkg::ST_IDLE && cmd_kind == 3'h0 && c_ov == 32'h0)
		|=> (setpoint_q == $past(cmd_target)) && !r_q.uni)
		else $error("zero overrun still approached");
	a_appr_dir_feed: assert property (@(posedge clk) disable iff (!rst_n)
		(r_q.st == aml_pkg::ST_APPR) |-> (feed_q == c_app) && (setpoint_q == r_q.final_tgt))
		else $error("approach leg wrong");
	a_prog_feed_cap: assert property (@(posedge clk) disable iff (!rst_n)
		(r_q.st == aml_pkg::ST_MOVE && r_q.kind == aml_pkg::K_FEED) |-> feed_q <= c_max)
		else $error("programmed feed above limit");
	a_jog_default: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && !cmd_stop && cmd_start && r_q.st == aml_pkg::ST_IDLE && cmd_kind == 3'h2 && cmd_feed == 32'h0)
		|=> feed_q == c_jog)
		else $error("jog feed not used");
	a_coupled_flag: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && c_ctl[3] && adiff(ferr_own, ferr_master) > c_cpl) |=> coupled_fault_q)
		else $error("coupled error missed");
	a_adv_analog: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && c_ctl[1:0] == 2'h2 && !c_ctl[4]) |=> dgain_accel_q && !dgain_ferr_q)
		else $error("advanced on analog not yes");
	a_hold_output: assert property (@(posedge clk) disable iff (!rst_n)
		hold_active_q |-> contact_q && hold_cmd_q == r_q.cfg[`AML_IDX_HOLD][14:0])
		else $error("hold command wrong");
	a_pos_offset: assert property (@(posedge clk) disable iff (!rst_n)
		(ce && c_ctl[15:8] != 8'h0) |=> pos_report_q == $past(feedback_pos) - $past(c_zoff))
		else $error("position offset not applied");
	a_seek_feed: assert property (@(posedge clk) disable iff (!rst_n)
		(r_q.st == aml_pkg::ST_SEEK2 || r_q.st == aml_pkg::ST_SHIFT) |-> feed_q == c_mseek)
		else $error("marker seek feed wrong");
endmodule
`default_nettype wire

/* File: verification/aml_servo_model.sv */
// Purpose: servo drive plus feedback device seen from one axis
// Assumes: position walks toward setpoint minus offset by step per clock
// Notes: freeze models a stalled axis; pins are registered copies of bench requests
`timescale 1ns/1ps
`default_nettype none
module aml_servo_model (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	// command from the axis and bench controls
	input  wire logic [31:0] setpoint,
	input  wire logic [31:0] step,
	input  wire logic [31:0] offset,
	input  wire logic [31:0] skew,
	input  wire logic        freeze,
	input  wire logic        home_req,
	input  wire logic        marker_req,
	// feedback towards the axis
	output logic      [31:0] feedback_pos,
	output logic      [31:0] ferr_own,
	output logic      [31:0] ferr_master,
	output logic             marker_pin,
	output logic             home_switch_pin
);
	logic signed [31:0] goal;
	logic signed [31:0] gap;
	// offset leaves a standing error so in-position windows can be told apart
	assign goal        = $signed(setpoint) - $signed(offset);
	assign gap         = goal - $signed(feedback_pos);
	assign ferr_own    = setpoint - feedback_pos;
	// skew stands for the master axis lagging behind its own command
	assign ferr_master = ferr_own + skew;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			feedback_pos    <= 32'h0;
			marker_pin      <= 1'b0;
			home_switch_pin <= 1'b0;
		end else begin
			marker_pin      <= marker_req;
			home_switch_pin <= home_req;
			if (freeze) begin
				feedback_pos <= feedback_pos;
			end else if (gap > $signed(step)) begin
				feedback_pos <= feedback_pos + step;
			end else if (gap < -$signed(step)) begin
				feedback_pos <= feedback_pos - step;
			end else begin
				feedback_pos <= goal;
			end
		end
	end
endmodule
`default_nettype wire

/* File: verification/tb_aml_axis.sv */
// Purpose: self-checking bench for the axis motion limiter
// Assumes: MS_CYC shortened to 4 so stall windows stay short
// Notes: register port and motion commands driven right after rising edges
`include "aml_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_aml_axis;
	logic clk = 1'b0, arst_n = 1'b0, ce = 1'b1, wr = 1'b0, rd = 1'b0;
	logic [7:0] addr = 8'h0;
	logic [31:0] wdata = 32'h0, cmd_target = 32'h0, cmd_feed = 32'h0;
	logic [2:0] cmd_kind = 3'h0;
	logic cmd_start = 1'b0, cmd_stop = 1'b0, freeze = 1'b0, home_req = 1'b0, marker_req = 1'b0;
	logic [31:0] step = 32'h0000_07d0, offset = 32'h0, skew = 32'h0;
	logic [31:0] rdata_q, setpoint_q, feed_q, pos_report_q, feedback_pos, ferr_own, ferr_master;
	logic busy_q, done_q, in_pos_q, short_move_q, coupled_fault_q, contact_q, hold_active_q;
	logic dgain_ferr_q, dgain_accel_q, smooth_stop_q, marker_pin, home_switch_pin;
	logic [1:0] marker_kind_q;
	logic [14:0] hold_cmd_q;
	int err_total = 0, num_checks = 0, cyc = 0;
	logic [31:0] rst_tab [17] = '{`AML_RST_RAPID, 32'h0, 32'h0, `AML_RST_MAX_PROGRAMMED_FEED, `AML_RST_MANUAL_JOG_FEED,
		`AML_RST_PROBE_FEEDRATE, `AML_RST_COUPLE, `AML_RST_CTRL, 32'h0, `AML_RST_MSEEK, 32'h0, 32'h0, 32'h0,
		`AML_RST_RCWIN, `AML_RST_INPOS, 32'h0, 32'h0};
	logic [31:0] exp_w;
	logic [3:0] u4, t4;

	aml_axis #(.MS_CYC(4)) dut (.clk(clk), .arst_n(arst_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata_q(rdata_q), .cmd_start(cmd_start), .cmd_stop(cmd_stop), .cmd_kind(cmd_kind),
		.cmd_target(cmd_target), .cmd_feed(cmd_feed), .feedback_pos(feedback_pos), .ferr_own(ferr_own),
		.ferr_master(ferr_master), .marker_pin(marker_pin), .home_switch_pin(home_switch_pin),
		.setpoint_q(setpoint_q), .feed_q(feed_q), .busy_q(busy_q), .done_q(done_q), .in_pos_q(in_pos_q),
		.short_move_q(short_move_q), .coupled_fault_q(coupled_fault_q), .contact_q(contact_q),
		.hold_active_q(hold_active_q), .hold_cmd_q(hold_cmd_q), .dgain_ferr_q(dgain_ferr_q),
		.dgain_accel_q(dgain_accel_q), .marker_kind_q(marker_kind_q), .smooth_stop_q(smooth_stop_q),
		.pos_report_q(pos_report_q));
	aml_servo_model servo (.clk(clk), .arst_n(arst_n), .setpoint(setpoint_q), .step(step), .offset(offset),
		.skew(skew), .freeze(freeze), .home_req(home_req), .marker_req(marker_req),
		.feedback_pos(feedback_pos), .ferr_own(ferr_own), .ferr_master(ferr_master),
		.marker_pin(marker_pin), .home_switch_pin(home_switch_pin));

	always #20 clk = ~clk;

	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// a hang is cut short well above the longest expected run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			final_report();
		end
	end
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp, input string what);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
		end
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk_word(rdata_q, exp, "read data");
	endtask
	task automatic start(input logic [2:0] k, input logic [31:0] t, input logic [31:0] f);
		@(posedge clk);
		cmd_kind   <= k;
		cmd_target <= t;
		cmd_feed   <= f;
		cmd_start  <= 1'b1;
		@(posedge clk);
		cmd_start <= 1'b0;
		#1;
	endtask
	task automatic stop;
		@(posedge clk);
		cmd_stop <= 1'b1;
		@(posedge clk);
		cmd_stop <= 1'b0;
		#1;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wait_done(input int n, input logic exp);
		logic seen;
		seen = 1'b0;
		for (int i = 0; i < n && !seen; i++) begin
			@(posedge clk);
			#1;
			if (done_q === 1'b1) seen = 1'b1;
		end
		chk_bit(seen, exp, "done pulse");
	endtask
	// rapid with overrun: first leg stops short, second leg runs at approach feed
	task automatic rapid_appr(input logic [31:0] t, input logic [31:0] first);
		start(aml_pkg::K_RAPID, t, 32'h0);
		chk_word(setpoint_q, first, "approach point");
		chk_word(feed_q, 32'h0012_3450, "rapid feed");
		for (int i = 0; i < 60 && setpoint_q !== t; i++) settle(1);
		chk_word(feed_q, 32'h0000_4e20, "approach feed");
		wait_done(60, 1'b1);
	endtask

	initial begin
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		for (int i = 0; i < 17; i++) reg_rd(8'(i * 4), rst_tab[i]);
		reg_wr(8'h48, 32'h0000_1234);
		reg_rd(8'h48, 32'h0);
		start(aml_pkg::K_RAPID, 32'h0000_9c40, 32'h0);
		chk_word(setpoint_q, 32'h0000_9c40, "no overrun target");
		chk_word(feed_q, `AML_RST_RAPID, "rapid default");
		chk_bit(busy_q, 1'b1, "busy at start");
		wait_done(60, 1'b1);
		settle(1);
		chk_bit(busy_q, 1'b0, "busy after done");
		reg_wr(8'h00, 32'h0012_3450);
		reg_wr(8'h04, 32'h0000_1388);
		reg_wr(8'h08, 32'h0000_4e20);
		rapid_appr(32'h0000_4e20, 32'h0000_3a98);
		reg_wr(8'h1c, 32'h0000_0005);
		rapid_appr(32'h0000_0000, 32'h0000_1388);
		reg_wr(8'h04, 32'h0);
		reg_wr(8'h1c, 32'h0000_0001);
		start(aml_pkg::K_FEED, 32'h0000_2710, 32'h7fff_0000);
		chk_word(feed_q, `AML_RST_MAX_PROGRAMMED_FEED, "feed cap");
		wait_done(60, 1'b1);
		reg_wr(8'h40, 32'h0000_0bb8);
		start(aml_pkg::K_FEED, 32'h0000_2af8, 32'h0000_03e8);
		chk_bit(short_move_q, 1'b1, "short move");
		wait_done(60, 1'b1);
		start(aml_pkg::K_JOG, 32'h0000_55f0, 32'h0);
		chk_bit(short_move_q, 1'b0, "long move");
		chk_word(feed_q, `AML_RST_MANUAL_JOG_FEED, "jog feed");
		wait_done(60, 1'b1);
		start(aml_pkg::K_PROBE, 32'h0000_5dc0, 32'h0);
		chk_word(feed_q, `AML_RST_PROBE_FEEDRATE, "probe feed");
		wait_done(60, 1'b1);
		offset <= 32'h0000_01f4;
		start(aml_pkg::K_FEED, 32'h0000_7530, 32'h0000_03e8);
		wait_done(40, 1'b0);
		chk_bit(in_pos_q, 1'b0, "outside window");
		stop();
		reg_wr(8'h1c, 32'h0000_0021);
		start(aml_pkg::K_FEED, 32'h0000_88b8, 32'h0000_03e8);
		wait_done(40, 1'b1);
		chk_bit(in_pos_q, 1'b1, "round corner window");
		offset <= 32'h0;
		// one axis per channel here, so every axis shares the select; last pass is advanced on a digital drive
		for (int i = 0; i < 4; i++) begin
			reg_wr(8'h1c, (i == 3) ? 32'h0000_0012 : 32'(i));
			settle(2);
			chk_bit(dgain_ferr_q, i == 0, "ferr gain");
			chk_bit(dgain_accel_q, i != 0, "accel gain");
		end
		skew <= 32'h0000_4e20;
		reg_wr(8'h1c, 32'h0000_0001);
		settle(3);
		chk_bit(coupled_fault_q, 1'b0, "master axis fault");
		reg_wr(8'h1c, 32'h0000_0009);
		settle(3);
		chk_bit(coupled_fault_q, 1'b1, "slave axis fault");
		skew <= 32'h0;
		reg_wr(8'h3c, 32'h0000_03e8);
		for (int i = 0; i < 8; i++) begin
			u4 = 4'(i % 4);
			t4 = 4'(i / 4);
			reg_wr(8'h1c, {16'h0, t4, u4, 8'h01});
			settle(2);
			chk_word({30'h0, marker_kind_q}, {28'h0, u4}, "marker kind");
			chk_bit(smooth_stop_q, t4[0], "smooth stop");
			exp_w = (i == 0) ? feedback_pos : feedback_pos - 32'h0000_03e8;
			chk_word(pos_report_q, exp_w, "position report");
		end
		reg_wr(8'h1c, 32'h0000_0001);
		reg_wr(8'h20, 32'h0000_0bb8);
		reg_wr(8'h24, 32'h0000_2000);
		start(aml_pkg::K_HOME, 32'h0003_0d40, 32'h0000_02bc);
		chk_word(feed_q, 32'h0000_02bc, "home first feed");
		settle(2);
		home_req <= 1'b1;
		settle(6);
		chk_word(feed_q, 32'h0000_2000, "marker seek feed");
		freeze <= 1'b1;
		settle(2);
		marker_req <= 1'b1;
		settle(2);
		marker_req <= 1'b0;
		settle(6);
		chk_word(setpoint_q, feedback_pos + 32'h0000_0bb8, "home shift");
		chk_word(feed_q, 32'h0000_2000, "shift feed");
		freeze <= 1'b0;
		home_req <= 1'b0;
		wait_done(30, 1'b1);
		reg_wr(8'h28, 32'h0000_0002);
		reg_wr(8'h2c, 32'h0000_000a);
		reg_wr(8'h30, 32'h0000_1234);
		step <= 32'h0000_0032;
		start(aml_pkg::K_HSTOP, 32'h0006_1a80, 32'h0000_03e8);
		settle(30);
		chk_bit(contact_q, 1'b0, "contact while moving");
		freeze <= 1'b1;
		settle(6);
		chk_bit(contact_q, 1'b0, "early contact");
		wait_done(30, 1'b1);
		chk_bit(hold_active_q, 1'b1, "hold active");
		chk_word({17'h0, hold_cmd_q}, 32'h0000_1234, "hold command");
		reg_rd(`AML_ADDR_STATUS, 32'h0000_8018);
		stop();
		settle(1);
		chk_bit(hold_active_q, 1'b0, "hold released");
		chk_word({17'h0, hold_cmd_q}, 32'h0, "hold cleared");
		final_report();
	end
endmodule
`default_nettype wire
